// ---- rtl/pgc_consts.vh ----
// constants for the pulse generator command parser
// assumes ASCII bytes arrive one per strobe
`ifndef PGC_CONSTS_VH
`define PGC_CONSTS_VH
`define PGC_MAX_LEN     8'hff
`define PGC_REPLY_LEN   5'h14
`define PGC_NPARAM      4'hc
`define PGC_CH_CR       8'h0d
`define PGC_CH_SP       8'h20
`define PGC_CH_COMMA    8'h2c
`define PGC_CH_SEMI     8'h3b
`define PGC_CH_DOT      8'h2e
`define PGC_CH_MINUS    8'h2d
`define PGC_CH_PLUS     8'h2b
`define PGC_CH_E        8'h45
`define PGC_CH_0        8'h30
`define PGC_CH_9        8'h39
`define PGC_SLOT_MAX    4'h9
// parameter indices
`define PGC_P_KIND      4'h0
`define PGC_P_FSRC      4'h1
`define PGC_P_EDTH      4'h2
`define PGC_P_ETTH      4'h3
`define PGC_P_RATE      4'h4
`define PGC_P_DLY       4'h5
`define PGC_P_WID       4'h6
`define PGC_P_STEADY    4'h7
`define PGC_P_FLOOR     4'h8
`define PGC_P_EXTM      4'h9
`define PGC_P_TOP       4'ha
`define PGC_P_SLOPE     4'hb
// fire source codes
`define PGC_FS_EXTDRV   32'h0
`define PGC_FS_EXTTH    32'h1
`define PGC_FS_INT      32'h2
`define PGC_FS_ONESHOT  32'h3
// error bits
`define PGC_ERR_UNREC   0
`define PGC_ERR_RANGE   1
`endif

// ---- rtl/pgc_parser.v ----
// command interpreter: parses ASCII command stream, holds parameters, replies
// assumes a byte strobe from the link and an external timing core and LCD
`timescale 1ns/1ps
`include "pgc_consts.vh"
module pgc_parser (
  input  wire        MCLK,
  input  wire        ARST_N,
  input  wire        RX_VALID,
  input  wire [7:0]  RX_DATA,
  input  wire        TX_READY,
  output wire        TX_VALID,
  output reg  [7:0]  TX_DATA,
  input  wire        ERR_READ,
  output reg  [7:0]  ERR_STATUS,
  input  wire        MODULE_PRESENT,
  output reg  [31:0] HW_PARAM,
  output reg  [3:0]  HW_INDEX,
  output reg         HW_LOAD,
  output reg         FIRE_PULSE,
  output reg         CYCLE_STOP,
  output reg  [3:0]  SLOT_INDEX,
  output reg         SLOT_SAVE,
  output reg         SLOT_LOAD,
  output reg  [1:0]  CARET_KEY,
  output reg         CARET_PRESS,
  output reg         LCD_ECHO,
  output reg         LCD_WRITE,
  output reg  [7:0]  LCD_CHAR,
  output reg  [4:0]  LCD_POS
);
  localparam S_IDLE = 2'h0;
  localparam S_REPLY = 2'h1;
  localparam S_CARET = 2'h2;
  localparam S_BULK = 2'h3;

  reg [31:0] temp_mem [0:11];
  reg [31:0] hw_mem   [0:11];
  reg [7:0]  tok_reg [0:2];
  reg [1:0]  ntok_reg;
  reg [2:0]  fld_reg;
  reg [31:0] val_reg;
  reg        have_val_reg;
  reg        val_neg_reg;
  reg [3:0]  frac_reg;
  reg        in_frac_reg;
  reg        in_exp_reg;
  reg        exp_neg_reg;
  reg [3:0]  exp_reg;
  reg        bad_num_reg;
  reg [7:0]  len_reg;
  reg        too_long_reg;
  reg        semi_reg;
  reg        lcd_str_reg;
  reg [4:0]  lcd_cnt_reg;
  reg [1:0]  state_reg;
  reg [4:0]  rcnt_reg;
  reg [3:0]  ridx_reg;
  reg [31:0] ccnt_reg;
  reg [3:0]  last_idx_reg;
  reg        last_armed_reg;
  reg [7:0]  sec2_reg;
  reg        tx_live_reg;
  wire       is_digit = RX_DATA >= `PGC_CH_0 && RX_DATA <= `PGC_CH_9;
  wire       is_sep = RX_DATA == `PGC_CH_SP || RX_DATA == `PGC_CH_COMMA;
  wire       is_end = RX_DATA == `PGC_CH_CR || RX_DATA == `PGC_CH_SEMI;
  wire       kw_done = RX_VALID && state_reg == S_IDLE && (is_sep || is_end);
  wire [15:0] w0 = {tok_reg[0], tok_reg[1]};

  // two-letter code compare, case sensitive
  function is_code;
    input [15:0] w;
    input [15:0] c;
    begin
      is_code = w == c;
    end
  endfunction

  // hex nibble as ascii digit for the reply field
  function [7:0] hexch;
    input [3:0] n;
    begin
      hexch = (n < 4'ha) ? (`PGC_CH_0 + {4'h0, n}) : (8'h37 + {4'h0, n});
    end
  endfunction

  // power of ten for value scaling
  function [31:0] pow10;
    input [3:0] n;
    integer k;
    begin
      pow10 = 32'h1;
      for (k = 0; k < 15; k = k + 1)
        if (k < n)
          pow10 = pow10 * 32'ha;
    end
  endfunction

  // reply character n: index, blank, 8 hex digits, blanks to the end
  function [7:0] reply_ch;
    input [4:0] n;
    begin
      if (n == 5'h0)
        reply_ch = hexch(ridx_reg);
      else if (n >= 5'h2 && n < 5'ha)
        reply_ch = hexch(temp_mem[ridx_reg][(5'h9 - n) * 4 +: 4]);
      else
        reply_ch = `PGC_CH_SP;
    end
  endfunction

  // scaled value: digits times 10^(exp - frac); negative exponents ignored
  wire [3:0]  up_exp = exp_neg_reg ? 4'h0 : exp_reg;
  wire [31:0] scaled = (up_exp >= frac_reg) ? val_reg * pow10(up_exp - frac_reg)
                       : val_reg / pow10(frac_reg - up_exp);

  // one cycle of preparation so the first reply byte is already registered
  assign TX_VALID = state_reg == S_REPLY && tx_live_reg;

  integer i;
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (i = 0; i < 12; i = i + 1) begin
        temp_mem[i] <= 32'h0;
        hw_mem[i] <= 32'h0;
      end
      tok_reg[0] <= 8'h0; tok_reg[1] <= 8'h0; tok_reg[2] <= 8'h0;
      ntok_reg <= 2'h0; fld_reg <= 3'h0; val_reg <= 32'h0; have_val_reg <= 1'b0;
      val_neg_reg <= 1'b0; frac_reg <= 4'h0; in_frac_reg <= 1'b0;
      in_exp_reg <= 1'b0; exp_neg_reg <= 1'b0; exp_reg <= 4'h0; bad_num_reg <= 1'b0;
      len_reg <= 8'h0; too_long_reg <= 1'b0; semi_reg <= 1'b0;
      lcd_str_reg <= 1'b0; lcd_cnt_reg <= 5'h0;
      state_reg <= S_IDLE; rcnt_reg <= 5'h0; ridx_reg <= 4'h0; ccnt_reg <= 32'h0;
      last_idx_reg <= 4'h0; last_armed_reg <= 1'b0;
      sec2_reg <= 8'h0; tx_live_reg <= 1'b0;
      ERR_STATUS <= 8'h0; HW_PARAM <= 32'h0; HW_INDEX <= 4'h0;
      HW_LOAD <= 1'b0; FIRE_PULSE <= 1'b0; CYCLE_STOP <= 1'b0; SLOT_INDEX <= 4'h0;
      SLOT_SAVE <= 1'b0; SLOT_LOAD <= 1'b0; CARET_KEY <= 2'h0; CARET_PRESS <= 1'b0;
      LCD_ECHO <= 1'b0; LCD_WRITE <= 1'b0; LCD_CHAR <= 8'h0; LCD_POS <= 5'h0;
    end else begin
      HW_LOAD <= 1'b0; FIRE_PULSE <= 1'b0; CYCLE_STOP <= 1'b0;
      SLOT_SAVE <= 1'b0; SLOT_LOAD <= 1'b0; CARET_PRESS <= 1'b0; LCD_WRITE <= 1'b0;
      if (ERR_READ)
        ERR_STATUS <= 8'h0;
      case (state_reg)
        S_REPLY: begin
          if (!tx_live_reg)
            tx_live_reg <= 1'b1;
          else if (TX_READY) begin
            rcnt_reg <= rcnt_reg + 5'h1;
            if (rcnt_reg == `PGC_REPLY_LEN - 5'h1) begin
              state_reg <= S_IDLE;
              tx_live_reg <= 1'b0;
            end
          end
        end
        S_CARET: begin
          CARET_PRESS <= 1'b1;
          ccnt_reg <= ccnt_reg - 32'h1;
          if (ccnt_reg <= 32'h1)
            state_reg <= S_IDLE;
        end
        S_BULK: begin
          HW_LOAD <= 1'b1;
          HW_INDEX <= ridx_reg;
          HW_PARAM <= temp_mem[ridx_reg];
          hw_mem[ridx_reg] <= temp_mem[ridx_reg];
          ridx_reg <= ridx_reg + 4'h1;
          if (ridx_reg == `PGC_NPARAM - 4'h1)
            state_reg <= S_IDLE;
        end
        default: begin
          if (RX_VALID) begin
            len_reg <= len_reg + 8'h1;
            if (len_reg == `PGC_MAX_LEN)
              too_long_reg <= 1'b1;
            if (lcd_str_reg && !is_sep && RX_DATA != `PGC_CH_CR) begin
              if (lcd_cnt_reg < `PGC_REPLY_LEN) begin
                LCD_WRITE <= 1'b1;
                LCD_CHAR <= RX_DATA;
                LCD_POS <= lcd_cnt_reg;
                lcd_cnt_reg <= lcd_cnt_reg + 5'h1;
              end
            end else if (is_sep || is_end) begin
              if (ntok_reg != 2'h0)
                fld_reg <= fld_reg + 3'h1;
              ntok_reg <= 2'h0;
              if (RX_DATA == `PGC_CH_SEMI)
                semi_reg <= 1'b1;
            end else if (fld_reg >= 3'h1 && (is_digit || RX_DATA == `PGC_CH_DOT ||
                         RX_DATA == `PGC_CH_MINUS || RX_DATA == `PGC_CH_PLUS ||
                         (have_val_reg && RX_DATA == `PGC_CH_E))) begin
              have_val_reg <= 1'b1;
              if (RX_DATA == `PGC_CH_E)
                in_exp_reg <= 1'b1;
              else if (RX_DATA == `PGC_CH_DOT)
                in_frac_reg <= 1'b1;
              else if (RX_DATA == `PGC_CH_MINUS) begin
                if (in_exp_reg)
                  exp_neg_reg <= 1'b1;
                else
                  val_neg_reg <= 1'b1;
              end else if (is_digit) begin
                if (in_exp_reg)
                  exp_reg <= exp_reg * 4'ha + RX_DATA[3:0];
                else begin
                  val_reg <= val_reg * 32'ha + {28'h0, RX_DATA[3:0]};
                  if (in_frac_reg)
                    frac_reg <= frac_reg + 4'h1;
                end
              end
            end else if (ntok_reg < 2'h2) begin
              if (fld_reg == 3'h0)
                tok_reg[ntok_reg] <= RX_DATA;
              else if (fld_reg == 3'h1) begin
                if (ntok_reg == 2'h0)
                  tok_reg[2] <= RX_DATA;
                else
                  sec2_reg <= RX_DATA;
              end
              ntok_reg <= ntok_reg + 2'h1;
              if (fld_reg == 3'h1 && ntok_reg == 2'h1 && w0 == "DS" &&
                  tok_reg[2] == "S" && RX_DATA == "T")
                lcd_str_reg <= 1'b1;
            end
            if (RX_DATA == `PGC_CH_CR) begin
              len_reg <= 8'h0; fld_reg <= 3'h0; ntok_reg <= 2'h0;
              val_reg <= 32'h0; have_val_reg <= 1'b0; val_neg_reg <= 1'b0;
              frac_reg <= 4'h0; in_frac_reg <= 1'b0; in_exp_reg <= 1'b0;
              exp_neg_reg <= 1'b0; exp_reg <= 4'h0; semi_reg <= 1'b0;
              lcd_str_reg <= 1'b0; lcd_cnt_reg <= 5'h0; too_long_reg <= 1'b0;
              tok_reg[2] <= 8'h0; sec2_reg <= 8'h0;
              if (too_long_reg)
                ERR_STATUS[`PGC_ERR_UNREC] <= 1'b1;
              else
                exec_cmd();
            end
          end
        end
      endcase
    end
  end

  // dispatch the completed command line
  task exec_cmd;
    reg [3:0]  pidx;
    reg        known;
    reg        valued;
    reg [15:0] sec;
    begin
      pidx = 4'h0;
      known = 1'b1;
      valued = 1'b0;
      sec = {tok_reg[2], sec2_reg};
      last_armed_reg <= 1'b0;
      if (is_code(w0, "MO")) begin
        pidx = `PGC_P_KIND;
        if (tok_reg[2] == 8'h0)
          start_reply(pidx);
        else if (sec == "PL" || sec == "IM" || sec == "CW" || sec == "EM")
          apply(pidx, {24'h0, tok_reg[2]});
        else
          known = 1'b0;
      end else if (is_code(w0, "TR")) begin
        pidx = `PGC_P_FSRC;
        case (sec)
          "ED": begin pidx = `PGC_P_EDTH; valued = 1'b1; end
          "ET": begin pidx = `PGC_P_ETTH; valued = 1'b1; end
          "IN": begin pidx = `PGC_P_RATE; valued = 1'b1; end
          "EP", "EN": apply(`PGC_P_SLOPE, {24'h0, sec2_reg});
          "SC": apply(`PGC_P_FSRC, `PGC_FS_ONESHOT);
          default: known = 1'b0;
        endcase
        if (valued && val_neg_reg && pidx == `PGC_P_RATE)
          ERR_STATUS[`PGC_ERR_RANGE] <= 1'b1;
        else if (valued && !have_val_reg)
          start_reply(pidx);
        else if (valued)
          apply(pidx, scaled);
      end else if (is_code(w0, "TI")) begin
        case (sec)
          "DL": begin pidx = `PGC_P_DLY; valued = 1'b1; end
          "WD": begin pidx = `PGC_P_WID; valued = 1'b1; end
          default: known = 1'b0;
        endcase
        if (valued && !have_val_reg)
          start_reply(pidx);
        else if (valued) begin
          if (!semi_reg)
            CYCLE_STOP <= 1'b1;
          apply(pidx, scaled);
        end
      end else if (is_code(w0, "LV")) begin
        case (sec)
          "AV": pidx = `PGC_P_STEADY;
          "BL": pidx = `PGC_P_FLOOR;
          "EM": pidx = `PGC_P_EXTM;
          "PK": pidx = `PGC_P_TOP;
          default: known = 1'b0;
        endcase
        if (known && !have_val_reg)
          start_reply(pidx);
        else if (known)
          apply(pidx, scaled);
      end else if (is_code(w0, "RE") || is_code(w0, "ST") || is_code(w0, "CL")) begin
        if (is_code(w0, "CL") && !MODULE_PRESENT)
          apply(`PGC_P_FSRC, `PGC_FS_ONESHOT);
        else if (!MODULE_PRESENT || (!is_code(w0, "CL") && (!have_val_reg ||
                 val_reg > {28'h0, `PGC_SLOT_MAX} || frac_reg != 4'h0)))
          ERR_STATUS[`PGC_ERR_RANGE] <= 1'b1;
        else begin
          SLOT_INDEX <= is_code(w0, "CL") ? 4'h0 : val_reg[3:0];
          SLOT_SAVE <= is_code(w0, "ST");
          SLOT_LOAD <= !is_code(w0, "ST");
        end
      end else if (is_code(w0, "FA") || is_code(w0, "FB") || is_code(w0, "FC")) begin
        known = 1'b1;
      end else if (is_code(w0, "LF") || is_code(w0, "RT") || is_code(w0, "UP") ||
                   is_code(w0, "DN")) begin
        CARET_KEY <= is_code(w0, "LF") ? 2'h0 : is_code(w0, "RT") ? 2'h1 :
                     is_code(w0, "UP") ? 2'h2 : 2'h3;
        ccnt_reg <= have_val_reg ? val_reg : 32'h1;
        state_reg <= S_CARET;
      end else if (is_code(w0, "DS")) begin
        if (sec == "ON")
          LCD_ECHO <= 1'b1;
        else if (sec == "OF")
          LCD_ECHO <= 1'b0;
        else if (sec != "ST")
          known = 1'b0;
      end else if (is_code(w0, "EX")) begin
        if (last_armed_reg)
          push_hw(last_idx_reg);
        else if (hw_mem[`PGC_P_FSRC] == `PGC_FS_ONESHOT)
          FIRE_PULSE <= 1'b1;
      end else if (is_code(w0, "RL")) begin
        ridx_reg <= 4'h0;
        state_reg <= S_BULK;
      end else
        known = 1'b0;
      if (!known)
        ERR_STATUS[`PGC_ERR_UNREC] <= 1'b1;
    end
  endtask

  // store value; push to hardware unless deferred
  task apply;
    input [3:0]  idx;
    input [31:0] v;
    begin
      temp_mem[idx] <= v;
      last_idx_reg <= idx;
      last_armed_reg <= semi_reg;
      if (!semi_reg)
        push_hw_val(idx, v);
    end
  endtask

  task push_hw;
    input [3:0] idx;
    begin
      push_hw_val(idx, temp_mem[idx]);
      last_armed_reg <= 1'b0;
    end
  endtask

  task push_hw_val;
    input [3:0]  idx;
    input [31:0] v;
    begin
      HW_LOAD <= 1'b1;
      HW_INDEX <= idx;
      HW_PARAM <= v;
      hw_mem[idx] <= v;
    end
  endtask

  // reply: param index then value in hex, padded to 20 characters
  task start_reply;
    input [3:0] idx;
    begin
      ridx_reg <= idx;
      rcnt_reg <= 5'h0;
      last_idx_reg <= idx;
      last_armed_reg <= 1'b1;
      state_reg <= S_REPLY;
    end
  endtask

  // reply character generator registered into TX_DATA
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      TX_DATA <= 8'h0;
    else if (state_reg == S_REPLY && !tx_live_reg)
      TX_DATA <= reply_ch(5'h0);
    else if (TX_VALID && TX_READY)
      TX_DATA <= reply_ch(rcnt_reg + 5'h1);
  end
endmodule // pgc_parser

// ---- bench/pgc_parser_sva.sv ----
// port assertions for the command parser
// assumes one clock, async active-low reset
`timescale 1ns/1ps
module pgc_parser_chk (
  input wire       MCLK,
  input wire       ARST_N,
  input wire       TX_VALID,
  input wire       TX_READY,
  input wire [7:0] TX_DATA,
  input wire       ERR_READ,
  input wire [7:0] ERR_STATUS,
  input wire       SLOT_SAVE,
  input wire       SLOT_LOAD,
  input wire [3:0] SLOT_INDEX,
  input wire       LCD_WRITE,
  input wire [4:0] LCD_POS,
  input wire       FIRE_PULSE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  reg [4:0] sent_reg;
  // reply bytes handed over so far
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) sent_reg <= 5'h00;
    else if (!TX_VALID) sent_reg <= 5'h00;
    else if (TX_READY) sent_reg <= sent_reg + 5'h01;
  end
  sequence s_reply_end;
    $fell(TX_VALID);
  endsequence
  a_reply_len: assert property (s_reply_end |-> sent_reg == 5'h14)
    else $error("reply not 20 bytes");
  a_reply_max: assert property (TX_VALID && TX_READY |-> sent_reg < 5'h14)
    else $error("reply longer than 20");
  a_reply_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("reply byte not held");
  a_err_zero: assert property (ERR_STATUS[7:2] == 6'h00)
    else $error("reserved error bits set");
  a_err_clear: assert property (ERR_READ |=> ERR_STATUS == 8'h00)
    else $error("error byte not cleared");
  a_err_keep: assert property (!ERR_READ |=>
    (ERR_STATUS & $past(ERR_STATUS)) == $past(ERR_STATUS))
    else $error("error bit lost");
  a_slot_range: assert property (SLOT_SAVE || SLOT_LOAD |-> SLOT_INDEX <= 4'h9)
    else $error("slot index above 9");
  a_lcd_pos: assert property (LCD_WRITE |-> LCD_POS < 5'h14)
    else $error("lcd position past 20");
  a_fire_single: assert property (FIRE_PULSE |=> !FIRE_PULSE)
    else $error("fire pulse too long");
endmodule // pgc_parser_chk
bind pgc_parser pgc_parser_chk pgc_parser_chk_inst (.MCLK(MCLK), .ARST_N(ARST_N),
  .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA), .ERR_READ(ERR_READ),
  .ERR_STATUS(ERR_STATUS), .SLOT_SAVE(SLOT_SAVE), .SLOT_LOAD(SLOT_LOAD),
  .SLOT_INDEX(SLOT_INDEX), .LCD_WRITE(LCD_WRITE), .LCD_POS(LCD_POS),
  .FIRE_PULSE(FIRE_PULSE));

// ---- bench/pgc_host.sv ----
// host controller model: sends command lines, collects replies
// assumes the parser is idle when a line starts
`timescale 1ns/1ps
module pgc_host (
  input  wire       MCLK,
  input  wire       TX_VALID,
  input  wire [7:0] TX_DATA,
  output reg        RX_VALID,
  output reg  [7:0] RX_DATA,
  output reg        TX_READY
);
  reg       slow;
  reg [7:0] rep [0:31];
  integer   nrep;
  initial begin
    RX_VALID = 1'b0;
    RX_DATA = 8'h00;
    TX_READY = 1'b1;
    slow = 1'b0;
    nrep = 0;
  end
  // reply byte taken only at an edge with ready high
  always @(posedge MCLK) begin
    if (TX_VALID && TX_READY) begin
      rep[nrep[4:0]] <= TX_DATA;
      nrep <= nrep + 1;
    end
    TX_READY <= slow ? ~TX_READY : 1'b1;
  end
  // line ends in carriage return, blanks separate fields
  task send(input string s);
    integer i;
    begin
      nrep = 0;
      for (i = 0; i <= s.len(); i = i + 1) begin
        @(posedge MCLK);
        RX_VALID <= 1'b1;
        RX_DATA <= (i == s.len()) ? 8'h0d : s[i];
      end
      @(posedge MCLK);
      RX_VALID <= 1'b0;
      RX_DATA <= ~RX_DATA;
    end
  endtask
endmodule // pgc_host

// ---- bench/pgc_parser_tb.sv ----
// self-checking bench for the command parser
// assumes pgc_host as the far side and the bound checker
`timescale 1ns/1ps
module pgc_parser_tb;
  typedef struct { string c; logic [3:0] x; logic [31:0] v; logic s; } row_t;
  reg         MCLK, ARST_N, ERR_READ, MODULE_PRESENT;
  wire        RX_VALID, TX_READY, TX_VALID, HW_LOAD, FIRE_PULSE, CYCLE_STOP;
  wire        SLOT_SAVE, SLOT_LOAD, CARET_PRESS, LCD_ECHO, LCD_WRITE;
  wire [7:0]  RX_DATA, TX_DATA, ERR_STATUS, LCD_CHAR;
  wire [31:0] HW_PARAM;
  wire [3:0]  HW_INDEX, SLOT_INDEX;
  wire [1:0]  CARET_KEY;
  wire [4:0]  LCD_POS;
  integer     mismatches, n_checks, cyc, nload, nfire, nstop, nsave, nrec, ncar, nlcd, i;
  reg [31:0]  lval;
  reg [3:0]   lidx, sidx;
  reg [1:0]   ckey;
  reg [7:0]   lch;
  string      s;
  row_t       rows [0:9];
  string      kc [0:5] = '{"MO PL", "MO IM", "MO CW", "MO EM", "TR EP", "TR EN"};
  reg [3:0]   kx [0:5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hb, 4'hb};
  pgc_parser pgc_parser_inst (.MCLK(MCLK), .ARST_N(ARST_N), .RX_VALID(RX_VALID),
    .RX_DATA(RX_DATA), .TX_READY(TX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .ERR_READ(ERR_READ), .ERR_STATUS(ERR_STATUS), .MODULE_PRESENT(MODULE_PRESENT),
    .HW_PARAM(HW_PARAM), .HW_INDEX(HW_INDEX), .HW_LOAD(HW_LOAD), .FIRE_PULSE(FIRE_PULSE),
    .CYCLE_STOP(CYCLE_STOP), .SLOT_INDEX(SLOT_INDEX), .SLOT_SAVE(SLOT_SAVE),
    .SLOT_LOAD(SLOT_LOAD), .CARET_KEY(CARET_KEY), .CARET_PRESS(CARET_PRESS),
    .LCD_ECHO(LCD_ECHO), .LCD_WRITE(LCD_WRITE), .LCD_CHAR(LCD_CHAR), .LCD_POS(LCD_POS));
  pgc_host pgc_host_inst (.MCLK(MCLK), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .TX_READY(TX_READY));
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // event counters for the current line
  always @(posedge MCLK) begin
    if (HW_LOAD === 1'b1) begin
      nload = nload + 1;
      lidx = HW_INDEX;
      lval = HW_PARAM;
    end
    if (FIRE_PULSE === 1'b1) nfire = nfire + 1;
    if (CYCLE_STOP === 1'b1) nstop = nstop + 1;
    if (SLOT_SAVE === 1'b1) nsave = nsave + 1;
    if (SLOT_LOAD === 1'b1) nrec = nrec + 1;
    if (SLOT_SAVE === 1'b1 || SLOT_LOAD === 1'b1) sidx = SLOT_INDEX;
    if (CARET_PRESS === 1'b1) ncar = ncar + 1;
    if (CARET_PRESS === 1'b1) ckey = CARET_KEY;
    if (LCD_WRITE === 1'b1 && nlcd == 0) lch = LCD_CHAR;
    if (LCD_WRITE === 1'b1) nlcd = nlcd + 1;
  end
  always @(posedge MCLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end
  task run(input string c);
    integer q, t;
    begin
      nload = 0; nfire = 0; nstop = 0; nsave = 0; nrec = 0; ncar = 0; nlcd = 0;
      pgc_host_inst.send(c);
      q = 0;
      for (t = 0; t < 400 && q < 12; t = t + 1) begin
        @(negedge MCLK);
        q = (TX_VALID || HW_LOAD || CARET_PRESS) ? 0 : q + 1;
      end
      $display("test %0s done", c);
    end
  endtask
  task err(input logic [7:0] e);
    begin
      chk(ERR_STATUS, e);
      @(posedge MCLK) ERR_READ <= 1'b1;
      @(posedge MCLK) ERR_READ <= 1'b0;
      @(negedge MCLK) chk(ERR_STATUS, 8'h00);
    end
  endtask
  initial begin
    mismatches = 0; n_checks = 0; cyc = 0;
    ARST_N = 1'b0; ERR_READ = 1'b0; MODULE_PRESENT = 1'b0;
    rows = '{'{"TR IN 5", 4'h4, 32'h5, 1'b0}, '{"TR ED 3", 4'h2, 32'h3, 1'b0},
      '{"TR ET 7", 4'h3, 32'h7, 1'b0}, '{"TI DL 12", 4'h5, 32'hc, 1'b1},
      '{"TI WD 1E2", 4'h6, 32'h64, 1'b1}, '{"LV AV 2", 4'h7, 32'h2, 1'b0},
      '{"LV  BL  4", 4'h8, 32'h4, 1'b0}, '{"LV EM 6", 4'h9, 32'h6, 1'b0},
      '{"LV PK 9", 4'ha, 32'h9, 1'b0}, '{"TR SC", 4'h1, 32'h3, 1'b0}};
    repeat (5) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(negedge MCLK);
    chk(LCD_ECHO, 1'b0);
    chk(TX_VALID, 1'b0);
    for (i = 0; i < 6; i = i + 1) begin
      run(kc[i]);
      chk(nload, 1);
      chk(lidx, kx[i]);
    end
    for (i = 0; i < 10; i = i + 1) begin
      run(rows[i].c);
      chk(nload, 1);
      chk(lidx, rows[i].x);
      chk(lval, rows[i].v);
      chk(nstop, rows[i].s);
    end
    run("EX"); chk(nfire, 1);
    run("TR IN 7;"); chk(nload, 0);
    run("EX"); chk(lval, 7); chk(nfire, 0);
    run("TR ED 8;"); run("LV PK 1"); run("TR ED"); chk(nload, 0);
    chk(pgc_host_inst.rep[0], "2");
    run("EX"); chk(lidx, 2); chk(lval, 8);
    run("TR ET 5;"); run("RL"); chk(nload != 0, 1);
    run("MO"); chk(pgc_host_inst.nrep, 20); chk(pgc_host_inst.rep[0], "0");
    pgc_host_inst.slow = 1'b1;
    run("TR IN"); chk(pgc_host_inst.nrep, 20); chk(pgc_host_inst.rep[9], "7");
    chk(pgc_host_inst.rep[1], " ");
    pgc_host_inst.slow = 1'b0;
    run("XX"); err(8'h01);
    run("tr in 5"); err(8'h01);
    run("TR IN -5"); chk(nload, 0); err(8'h02);
    @(posedge MCLK) MODULE_PRESENT <= 1'b1;
    run("ST 3"); chk(nsave, 1); chk(sidx, 3);
    run("RE 9"); chk(nrec, 1); chk(sidx, 9);
    run("ST 10"); chk(nsave, 0); err(8'h02);
    run("LF 3"); chk(ncar, 3); chk(ckey, 0);
    run("UP"); chk(ncar, 1); chk(ckey, 2);
    run("DS ON"); chk(LCD_ECHO, 1); chk(nload, 0);
    run("DS ST HI"); chk(nlcd, 2); chk(nload, 0);
    chk(lch, "H");
    run("DS OFF"); chk(LCD_ECHO, 0);
    run("FA"); chk(nload + nfire, 0); err(8'h00);
    @(posedge MCLK) MODULE_PRESENT <= 1'b1;
    run("CL"); chk(nrec, 1); chk(sidx, 0);
    @(posedge MCLK) MODULE_PRESENT <= 1'b0;
    run("CL"); chk(nrec, 0); chk(lval, 3);
    s = "";
    repeat (260) s = {s, " "};
    run({s, "MO PL"}); chk(nload, 0); err(8'h01);
    complete_run;
  end
endmodule // pgc_parser_tb
